/* inc/scan_master_pkg.sv */
// constants, register map and carrier types of the scan master engine
// assumes a 10 MHz system clock and a zero-wait AHB-Lite register slave
package scan_master_pkg;

    // bus and data widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DOR_COUNT = 4;
    localparam int unsigned FRAME_MAX = DOR_COUNT * DATA_W;
    localparam int unsigned CNT_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_MCR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DOR0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DOR3 = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_CAPT = 8'h20;

    // ahb transfer codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;

    // test clock select codes
    localparam logic [1:0] TEST_CLOCK_SELECT_NONE = 2'h0;

    // timing: system clock and internal test clock periods in ns
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TCK1_PERIOD_NS = 400;
    localparam int unsigned TCK2_PERIOD_NS = 800;
    localparam int unsigned TCK3_PERIOD_NS = 1600;
    localparam int unsigned DIV_W = 4;
    // half periods in system cycles, rounded down, never below one
    localparam logic [DIV_W-1:0] TCK1_HALF = DIV_W'(TCK1_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [DIV_W-1:0] TCK2_HALF = DIV_W'(TCK2_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [DIV_W-1:0] TCK3_HALF = DIV_W'(TCK3_PERIOD_NS / (2 * CLK_PERIOD_NS));

    // module configuration register layout
    typedef struct packed {
        logic [26:0] rsvd;           // reads zero
        logic idle_irq_enable;       // bit 4
        logic [1:0] test_clock_select; // bits 3:2
        logic transfer_mode_bit;     // bit 1
        logic soft_reset_bit;        // bit 0
    } module_config_reg_t;
    localparam module_config_reg_t MCR_RESET = '0;

    // control register layout
    typedef struct packed {
        logic [22:0] rsvd;
        logic start;                 // bit 8, write one to launch
        logic [CNT_W-1:0] length;    // bits 7:0, frame bits
    } ctrl_reg_t;

    // status register bit positions
    localparam int unsigned SR_IDLE = 0;
    localparam int unsigned SR_BUSY = 1;
    localparam int unsigned SR_CLOCKED = 2;
    localparam int unsigned SR_TOOL = 3;

    // captured address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] size;
        logic [ADDR_W-1:0] addr;
    } addr_phase_t;

    // frame engine states
    typedef enum logic [0:0] {
        FS_IDLE = 1'b0,
        FS_SHIFT = 1'b1
    } frame_state_t;

endpackage

/* rtl/scan_sync.sv */
// two-flop synchroniser for pins entering the system clock domain
// assumes inputs are asynchronous levels; only the second stage is read
`timescale 1ns/1ns
module scan_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // a synchroniser without a bit cannot be built
    if (WIDTH == 0) begin : g_bad_width
        $error("scan_sync needs at least one bit");
    end

    // first and second stage
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // both stages clear to zero under reset
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end

    assign o_sync = stage2;

endmodule // scan_sync

/* rtl/scan_master_engine.sv */
// scan master engine: ahb-lite registers, test clock and frame shifter
// assumes one ahb master, tool pins asynchronous to I_CLK (10 MHz)
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
// Overview of operation
// [RULE_01] soft reset clears engine, then self-clears
// [RULE_02] self-clear only when the engine is clocked
// [RULE_03] software enables clocking before soft reset
// [RULE_04] transfer mode meant to guard data writes
// [RULE_05] data output registers always writable
// [RULE_06] stale idle flag interrupts once enabled
// [RULE_07] software clears idle before enabling interrupt
// [RULE_08] narrow writes widen, other bytes zero
// [RULE_09] frame end sets idle; irq is idle&enable
module scan_master_engine
    import scan_master_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [ADDR_W-1:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [DATA_W-1:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [DATA_W-1:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // external tool and scan pins
    input wire logic I_TOOL_PRESENT,
    input wire logic I_TOOL_TCK,
    input wire logic I_TDO,
    output logic O_TCK,
    output logic O_TCK_OE,
    output logic O_TMS,
    output logic O_TDI,
    // interrupt request
    output logic O_IRQ
);
    // state of the block apart from the pin synchroniser stages
    typedef struct packed {
        addr_phase_t ap;                // pending data phase
        logic [DATA_W-1:0] rdata;       // read data for the data phase
        module_config_reg_t module_config_reg;        // configuration
        logic idle;                     // sticky frame-done flag
        logic [DOR_COUNT-1:0][DATA_W-1:0] dor; // data output regs
        logic [DATA_W-1:0] capt;        // last bits seen on tdo
        frame_state_t fs;               // frame state
        logic [CNT_W-1:0] cnt;          // bits left in the frame
        logic [FRAME_MAX-1:0] shreg;    // bits still to present
        logic [DIV_W-1:0] div;          // internal tck divider
        logic tck;                      // internal tck level
        logic tool_tck_q;               // previous synced tool tck
        logic tdi;
        logic tms;
    } state_t;

    state_t st;
    state_t next_st;

    // synchronised pins
    logic [2:0] pins_sync;
    logic tool_on;
    logic tool_tck_s;
    logic tdo_s;

    scan_sync #(
        .WIDTH(3)
    ) u_sync (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .i_async({I_TOOL_PRESENT, I_TOOL_TCK, I_TDO}),
        .o_sync(pins_sync)
    );

    assign tool_on = pins_sync[2];
    assign tool_tck_s = pins_sync[1];
    assign tdo_s = pins_sync[0];

    // byte lanes kept by a narrow write; the others are forced to zero
    function automatic logic [DATA_W-1:0] widen(input logic [DATA_W-1:0] d,
            input logic [1:0] a, input logic [2:0] sz);
        logic [DATA_W-1:0] m;
        m = '1;
        if (sz == HSIZE_BYTE) begin
            m = DATA_W'(32'h0000_00ff) << {a, 3'h0};
        end else if (sz == HSIZE_HALF) begin
            m = DATA_W'(32'h0000_ffff) << {a[1], 4'h0};
        end
        return d & m;
    endfunction

    // internal half period from the select code
    function automatic logic [DIV_W-1:0] half_of(input logic [1:0] sel);
        logic [DIV_W-1:0] h;
        h = TCK3_HALF;
        if (sel == 2'h1) begin
            h = TCK1_HALF;
        end else if (sel == 2'h2) begin
            h = TCK2_HALF;
        end
        return h;
    endfunction

    // combinational helpers
    logic int_on;           // internal test clock running
    logic clocked;          // engine receives clock edges
    logic tick;             // one rising test clock edge
    logic [DATA_W-1:0] wdata;
    ctrl_reg_t ctrl_w;
    logic [DATA_W-1:0] sr_val;
    logic [2:0] dor_idx;

    // status word seen by software
    always_comb begin
        sr_val = '0;
        sr_val[SR_IDLE] = st.idle;
        sr_val[SR_BUSY] = (st.fs == FS_SHIFT);
        sr_val[SR_CLOCKED] = clocked;
        sr_val[SR_TOOL] = tool_on;
    end

    // next state
    always_comb begin
        next_st = st;
        // internal clock needs transfer mode and a valid select
        int_on = st.module_config_reg.transfer_mode_bit && (st.module_config_reg.test_clock_select != TEST_CLOCK_SELECT_NONE); // RULE_02
        clocked = tool_on || int_on; // RULE_02
        tick = 1'b0;
        wdata = widen(I_HWDATA, st.ap.addr[1:0], st.ap.size); // RULE_08
        ctrl_w = ctrl_reg_t'(wdata);
        dor_idx = 3'(st.ap.addr[4:2]);

        // test clock source: the tool wins when attached
        next_st.tool_tck_q = tool_tck_s;
        if (tool_on) begin
            tick = tool_tck_s && !st.tool_tck_q;
            next_st.div = '0;
            next_st.tck = 1'b0;
        end else if (int_on) begin
            if (st.div == '0) begin
                next_st.div = half_of(st.module_config_reg.test_clock_select) - DIV_W'(1);
                next_st.tck = !st.tck;
                tick = !st.tck;
            end else begin
                next_st.div = st.div - DIV_W'(1);
            end
        end else begin
            // unclocked: a pending soft reset waits here
            next_st.div = '0;
            next_st.tck = 1'b0;
        end

        // engine work on each test clock edge
        if (tick && st.module_config_reg.soft_reset_bit) begin
            // soft reset clears the engine and then itself
            next_st.fs = FS_IDLE; // RULE_01
            next_st.cnt = '0;
            next_st.shreg = '0;
            next_st.tdi = 1'b0;
            next_st.tms = 1'b0;
            next_st.module_config_reg.soft_reset_bit = 1'b0; // RULE_02
        end else if (tick && st.fs == FS_SHIFT) begin
            // target took the current bit; move on
            next_st.capt = {tdo_s, st.capt[DATA_W-1:1]};
            next_st.cnt = st.cnt - CNT_W'(1);
            if (st.cnt == CNT_W'(1)) begin
                next_st.fs = FS_IDLE;
                next_st.tms = 1'b0;
            end else begin
                next_st.tdi = st.shreg[0];
                next_st.shreg = st.shreg >> 1;
                next_st.tms = (st.cnt == CNT_W'(2));
            end
        end

        // data phase of a write
        if (st.ap.valid && st.ap.write) begin
            if (st.ap.addr == OFF_MCR) begin
                next_st.module_config_reg = module_config_reg_t'(wdata);
                next_st.module_config_reg.rsvd = '0;
                // a write of one wins over a same-cycle self-clear
                next_st.module_config_reg.soft_reset_bit = wdata[0]; // RULE_01
            end else if (st.ap.addr == OFF_SR) begin
                if (wdata[SR_IDLE]) begin
                    next_st.idle = 1'b0; // RULE_07
                end
            end else if (st.ap.addr == OFF_CTRL) begin
                // launch only when idle, not in soft reset, length legal
                if (ctrl_w.start && st.fs == FS_IDLE && !st.module_config_reg.soft_reset_bit
                        && ctrl_w.length != '0
                        && 32'(ctrl_w.length) <= FRAME_MAX) begin
                    next_st.fs = FS_SHIFT;
                    next_st.cnt = ctrl_w.length;
                    next_st.tdi = st.dor[0][0];
                    next_st.shreg = st.dor >> 1;
                    next_st.tms = (ctrl_w.length == CNT_W'(1));
                end
            end else if (st.ap.addr >= OFF_DOR0 && st.ap.addr <= OFF_DOR3) begin // RULE_04
                // no transfer mode check on these writes
                next_st.dor[dor_idx[1:0]] = wdata; // RULE_05
            end
        end

        // frame end sets the flag; the set beats a same-cycle clear
        if (tick && !st.module_config_reg.soft_reset_bit && st.fs == FS_SHIFT && st.cnt == CNT_W'(1)) begin
            next_st.idle = 1'b1; // RULE_09
        end

        // address phase capture and read data
        next_st.ap.valid = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ || I_HTRANS[1]);
        next_st.ap.write = I_HWRITE;
        next_st.ap.size = I_HSIZE;
        next_st.ap.addr = I_HADDR;
        next_st.rdata = '0;
        if (next_st.ap.valid && !I_HWRITE) begin
            if (I_HADDR == OFF_MCR) begin
                next_st.rdata = st.module_config_reg;
            end else if (I_HADDR == OFF_SR) begin
                next_st.rdata = sr_val;
            end else if (I_HADDR >= OFF_DOR0 && I_HADDR <= OFF_DOR3) begin
                next_st.rdata = st.dor[I_HADDR[3:2]];
            end else if (I_HADDR == OFF_CAPT) begin
                next_st.rdata = st.capt;
            end
        end
    end

    // one register for the whole state
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st <= '0;
            st.module_config_reg <= MCR_RESET;
            st.fs <= FS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign O_HRDATA = st.rdata;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_TCK = st.tck;
    assign O_TCK_OE = int_on && !tool_on;
    assign O_TMS = st.tms;
    assign O_TDI = st.tdi;
    // a stale flag fires as soon as the enable rises
    assign O_IRQ = st.idle && st.module_config_reg.idle_irq_enable; // RULE_06

endmodule // scan_master_engine

/* testbench/scan_master_engine_monitor.sv */
// port checker for the scan master engine
// assumes one ahb-lite master and the engine as the only slave
`timescale 1ns/1ns
module scan_master_monitor
    import scan_master_pkg::*;
(
    // watched ports
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_HSEL,
    input wire logic [ADDR_W-1:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [DATA_W-1:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic [DATA_W-1:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic I_TOOL_PRESENT,
    input wire logic O_TCK_OE,
    input wire logic O_TMS,
    input wire logic O_IRQ
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    logic rd_ph; // read data phase now
    logic wr_ph; // write data phase now
    logic [ADDR_W-1:0] ph_addr; // address of that phase
    // follow the bus into its data phase
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
            ph_addr <= '0;
        end else begin
            rd_ph <= I_HSEL & I_HREADY & I_HTRANS[1] & !I_HWRITE;
            wr_ph <= I_HSEL & I_HREADY & I_HTRANS[1] & I_HWRITE;
            ph_addr <= I_HADDR;
        end
    end
    a_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
        else $error("bus answer not ready and okay");
    a_rdata_quiet: assert property (!rd_ph |-> O_HRDATA == '0)
        else $error("read data outside a read data phase");
    a_tool_owns_tck: assert property (I_TOOL_PRESENT [*4] |-> !O_TCK_OE)
        else $error("test clock driven while tool attached");
    a_irq_needs_en: assert property (
        wr_ph && ph_addr == OFF_MCR && !I_HWDATA[4] |=> !O_IRQ)
        else $error("irq with enable written low");
    a_idle_clear: assert property (
        wr_ph && ph_addr == OFF_SR && I_HWDATA[SR_IDLE] && !O_TMS |=> !O_IRQ)
        else $error("irq after idle flag cleared");
    a_irq_sr_view: assert property (
        rd_ph && ph_addr == OFF_SR && !O_HRDATA[SR_IDLE] |-> !$past(O_IRQ))
        else $error("irq while idle reads low");
    a_irq_mcr_view: assert property (
        rd_ph && ph_addr == OFF_MCR && !O_HRDATA[4] |-> !$past(O_IRQ))
        else $error("irq while enable reads low");
    a_irq_fall_cause: assert property ($fell(O_IRQ) |-> $past(wr_ph) &&
        ($past(ph_addr) == OFF_SR || $past(ph_addr) == OFF_MCR))
        else $error("pending idle irq lost without a write");
endmodule // scan_master_monitor

bind scan_master_engine scan_master_monitor mon (.I_CLK, .I_RST_N, .I_HSEL, .I_HADDR,
    .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT, .O_HRESP,
    .I_TOOL_PRESENT, .O_TCK_OE, .O_TMS, .O_IRQ);

/* testbench/scan_tool_model.sv */
// far side: debug tool presence, tool test clock and scan target
// assumes the engine's own test clock when no tool is attached
`timescale 1ns/1ns
module scan_tool_model (
    // bench controls
    input wire logic i_tool_en,
    input wire logic i_run,
    // engine test clock
    input wire logic i_tck,
    // pins toward the engine
    output logic o_present,
    output logic o_tool_tck,
    output logic o_tdo
);
    logic [31:0] pat = 32'h3c5a96e1; // target shift pattern
    wire logic eff_tck = i_tool_en ? o_tool_tck : i_tck; // clock the target sees
    initial o_tool_tck = 1'b0;
    assign o_present = i_tool_en;
    // tool clock, 800 ns, stands low outside transfers
    always #400 o_tool_tck = i_tool_en & i_run & ~o_tool_tck;
    // target moves its data on the falling edge
    always @(negedge eff_tck) pat <= {pat[0], pat[31:1]};
    // idle tool target lets tdo float to its pull-up
    assign o_tdo = (i_run | ~i_tool_en) ? pat[0] : 1'b1;
endmodule // scan_tool_model

/* testbench/tb_top.sv */
// self-checking bench for the scan master engine
// assumes the engine, its port checker and the tool model
`timescale 1ns/1ns
module tb_top
    import scan_master_pkg::*;
;
    // bench-driven inputs
    logic I_CLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic I_HSEL = 1'b0;
    logic [ADDR_W-1:0] I_HADDR = '0;
    logic [1:0] I_HTRANS = '0;
    logic I_HWRITE = 1'b0;
    logic [2:0] I_HSIZE = 3'h2;
    logic [DATA_W-1:0] I_HWDATA = '0;
    logic tool_en = 1'b0; // tool attached
    logic run = 1'b0; // tool clock wanted
    // design outputs and far-side lines
    logic [DATA_W-1:0] O_HRDATA;
    logic I_HREADY, I_TOOL_PRESENT, I_TOOL_TCK, I_TDO;
    logic O_HREADYOUT, O_HRESP, O_TCK, O_TCK_OE, O_TMS, O_TDI, O_IRQ;
    int n_mismatch = 0;
    int checked = 0;
    assign I_HREADY = O_HREADYOUT;
    always #50 I_CLK = ~I_CLK;
    scan_master_engine dut (.I_CLK, .I_RST_N, .I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE,
        .I_HSIZE, .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT, .O_HRESP, .I_TOOL_PRESENT,
        .I_TOOL_TCK, .I_TDO, .O_TCK, .O_TCK_OE, .O_TMS, .O_TDI, .O_IRQ);
    scan_tool_model tool (.i_tool_en(tool_en), .i_run(run), .i_tck(O_TCK),
        .o_present(I_TOOL_PRESENT), .o_tool_tck(I_TOOL_TCK), .o_tdo(I_TDO));
    // verdict and end of run
    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // compare one word
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // wait for hready at a rising edge, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_HREADYOUT !== 1'b1 && n < 64);
        if (O_HREADYOUT !== 1'b1) begin
            chk("hready wait", 32'h1, 32'h0);
            stop_test;
        end
    endtask
    // one single transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] sz,
        input logic [31:0] wd, output logic [31:0] rd);
        I_HSEL <= 1'b1;
        I_HADDR <= a;
        I_HTRANS <= HTRANS_NONSEQ;
        I_HWRITE <= w;
        I_HSIZE <= sz;
        wait_rdy;
        I_HSEL <= 1'b0;
        I_HTRANS <= 2'h0;
        I_HWDATA <= wd;
        wait_rdy;
        rd = O_HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, 3'h2, d, x);
    endtask
    // read and compare the masked bits
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string what);
        logic [31:0] x;
        xfer(1'b0, a, 3'h2, '0, x);
        chk(what, e, x & m);
    endtask
    // read until masked bits match, bounded
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] x;
        for (int i = 0; i < 200; i++) begin
            xfer(1'b0, a, 3'h2, '0, x);
            if ((x & m) === e) return;
        end
        chk("poll", e, x & m);
        stop_test;
    endtask
    // irq level once the last write has landed
    task automatic irq_is(input logic e);
        @(negedge I_CLK);
        chk("irq", {31'h0, e}, {31'h0, O_IRQ});
        @(posedge I_CLK);
    endtask
    // tdi, tms and tck enable right after the last write landed
    task automatic pins_are(input logic [2:0] e);
        @(negedge I_CLK);
        chk("tdi tms oe", {29'h0, e}, {29'h0, O_TDI, O_TMS, O_TCK_OE});
        @(posedge I_CLK);
    endtask
    // cycles between two rising edges of the internal test clock
    task automatic tck_period(input logic [31:0] e);
        int n;
        int t0;
        logic q;
        logic done;
        n = 0;
        t0 = -1;
        q = O_TCK;
        done = 1'b0;
        while (!done && n < 64) begin
            @(negedge I_CLK);
            n++;
            if (O_TCK === 1'b1 && q === 1'b0) begin
                if (t0 >= 0) begin
                    chk("tck period", e, 32'(n - t0));
                    done = 1'b1;
                end
                t0 = n;
            end
            q = O_TCK;
        end
        if (!done) begin
            chk("tck period", e, 32'h0);
            stop_test;
        end
        @(posedge I_CLK);
    endtask
    // data registers writable with transfer mode off, narrow writes widen
    task automatic s_dor;
        logic [31:0] x;
        wr(OFF_MCR, 32'h0);
        for (int i = 0; i < DOR_COUNT; i++) begin
            wr(OFF_DOR0 + 8'(4 * i), 32'h11111111 * (i + 1));
            rd(OFF_DOR0 + 8'(4 * i), '1, 32'h11111111 * (i + 1), "dor");
        end
        xfer(1'b1, OFF_DOR0 + 8'h4, HSIZE_BYTE, 32'h5a5a5aa5, x);
        rd(OFF_DOR0 + 8'h4, '1, 32'h000000a5, "dor byte");
        xfer(1'b1, OFF_DOR3, HSIZE_HALF, 32'hdeadbeef, x);
        rd(OFF_DOR3, '1, 32'h0000beef, "dor half");
        wr(8'h3c, '1);
        rd(8'h3c, '1, 32'h0, "unmapped");
    endtask
    // soft reset stuck unclocked, freed by internal clock, then by the tool
    task automatic s_soft_reset;
        wr(OFF_MCR, 32'h1);
        repeat (30) @(posedge I_CLK);
        rd(OFF_MCR, '1, 32'h1, "mcr unclocked");
        wr(OFF_MCR, 32'h7);
        poll(OFF_MCR, 32'h1, 32'h0);
        rd(OFF_MCR, '1, 32'h6, "mcr self clear");
        tck_period(TCK1_PERIOD_NS / CLK_PERIOD_NS);
        wr(OFF_MCR, 32'h1);
        tool_en <= 1'b1;
        run <= 1'b1;
        poll(OFF_MCR, 32'h1, 32'h0);
        rd(OFF_MCR, '1, 32'h0, "mcr tool clear");
        run <= 1'b0;
        tool_en <= 1'b0;
    endtask
    // frame end with enable low stays pending; clearing first avoids it
    task automatic s_frame;
        wr(OFF_MCR, 32'ha);
        tck_period(TCK2_PERIOD_NS / CLK_PERIOD_NS);
        wr(OFF_DOR0, 32'h5b);
        wr(OFF_CTRL, 32'h108);
        pins_are(3'h5);
        poll(OFF_SR, 32'h3, 32'h1);
        pins_are(3'h1);
        irq_is(1'b0);
        wr(OFF_MCR, 32'h1a);
        irq_is(1'b1);
        wr(OFF_SR, 32'h1);
        irq_is(1'b0);
        wr(OFF_MCR, 32'ha);
        tool_en <= 1'b1;
        run <= 1'b1;
        wr(OFF_CTRL, 32'h101);
        pins_are(3'h6);
        poll(OFF_SR, 32'h3, 32'h1);
        run <= 1'b0;
        wr(OFF_SR, 32'h1);
        rd(OFF_SR, 32'h1, 32'h0, "idle cleared");
        wr(OFF_MCR, 32'h1a);
        irq_is(1'b0);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        @(posedge I_CLK);
        rd(OFF_MCR, '1, MCR_RESET, "mcr reset");
        s_dor;
        s_soft_reset;
        s_frame;
        stop_test;
    end
endmodule // tb_top
